// ==== verilog/mcio_top.v ====
/*
 * Module configuration and I/O select: power-up sampling of address pins
 * and programming-pad short, node and reply address selection, serial rate
 * setting, CAN gating by USB, limit-switch gating of step pulses, and the
 * analog input read as code or digital level. APB slave for software.
 * Assumes synchronous pin inputs and a converter that delivers 12-bit codes.
 */
`timescale 1ns/1ns
`include "mcio_defs.vh"

module mcio_top #(
	parameter INIT_CYC = `MCIO_INIT_CYC
) (
	input  wire        pclk,            // Clock, 125 MHz
	input  wire        presetn,         // Async reset, active low
	input  wire        psel,            // APB select
	input  wire        penable,         // APB enable
	input  wire        pwrite,          // APB write
	input  wire [11:0] paddr,           // APB byte address
	input  wire [31:0] pwdata,          // APB write data
	output reg  [31:0] prdata,          // APB read data
	output reg         pready,          // APB ready
	output reg         pslverr,         // APB error
	input  wire        node_sel_bit0,   // Address pin bit 0
	input  wire        node_sel_bit1,   // Address pin bit 1
	input  wire        node_sel_bit2,   // Address pin bit 2
	input  wire        node_sel_bit3,   // Address pin bit 3
	input  wire        prog_clk_pad,    // Programming clock pad
	input  wire        prog_data_pad,   // Programming data pad
	input  wire        usb_present,     // USB connection present
	input  wire        stop_left,       // Left limit switch, active high
	input  wire        stop_right,      // Right limit switch, active high
	input  wire        ext_step,        // External step input
	input  wire        ext_dir,         // External direction, 1 = positive
	input  wire        int_step,        // Internal controller step
	input  wire        int_dir,         // Internal controller direction
	input  wire [11:0] adc_code,        // Converter result
	input  wire        adc_valid,       // Converter result strobe
	input  wire        ain_level,       // Analog pin as digital level
	output reg         init_done,       // Power-up sampling finished
	output reg         factory_restore, // Restore defaults to settings store
	output reg  [7:0]  module_addr,     // Active module address
	output reg  [7:0]  reply_addr,      // Active reply address
	output reg  [7:0]  canopen_node_id, // Active node identifier
	output reg  [31:0] rs485_baud,      // Serial bit rate
	output reg         can_enable,      // CAN interface enabled
	output reg         motor_step,      // Step pulse to motor driver
	output reg         motor_dir        // Direction to motor driver
);

	// ------------------------------------------------------------------
	// Init sequencer
	// ------------------------------------------------------------------
	localparam [2:0] S_WAIT = 3'b001;
	localparam [2:0] S_LOAD = 3'b010;
	localparam [2:0] S_RUN  = 3'b100;

	reg  [2:0]  state_r;
	reg  [2:0]  state_nxt;
	reg  [31:0] wait_cnt_r;
	wire        load_pulse = (state_r == S_LOAD);
	wire [3:0]  pins_live = {node_sel_bit3, node_sel_bit2, node_sel_bit1, node_sel_bit0};
	wire [3:0]  pins_q;
	wire [0:0]  short_q;
	wire        pad_short = prog_clk_pad & prog_data_pad;

	always @* begin
		state_nxt = state_r;
		case (state_r)
			S_WAIT: begin
				if (wait_cnt_r >= INIT_CYC - 1)
					state_nxt = S_LOAD;
			end
			S_LOAD:  state_nxt = S_RUN;
			S_RUN:   state_nxt = S_RUN;
			default: state_nxt = S_WAIT;
		endcase
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_r    <= S_WAIT;
			wait_cnt_r <= 32'h0;
		end else begin
			state_r <= state_nxt;
			if (state_r == S_WAIT)
				wait_cnt_r <= wait_cnt_r + 32'h1;
		end
	end

	// Sampled once; later pin changes are ignored until next reset
	mcio_pin_latch #(.W(4)) u_pins (
		.pclk    (pclk),
		.presetn (presetn),
		.load    (load_pulse),
		.d       (pins_live),
		.q       (pins_q)
	);

	mcio_pin_latch #(.W(1)) u_short (
		.pclk    (pclk),
		.presetn (presetn),
		.load    (load_pulse),
		.d       (pad_short),
		.q       (short_q)
	);

	// ------------------------------------------------------------------
	// Software registers
	// ------------------------------------------------------------------
	reg  [`MCIO_CTRL_W-1:0] ctrl_r;
	reg  [7:0]              stored_addr_r;
	reg  [31:0]             baud_r;
	reg  [11:0]             adc_r;
	reg                     restore_r;

	wire wr_en = psel & penable & pwrite & pready;
	wire pins_used = (pins_q != `MCIO_NODE_PINS_ZERO);
	wire blk_left  = ctrl_r[`MCIO_CTRL_LIM_L_EN] & stop_left;
	wire blk_right = ctrl_r[`MCIO_CTRL_LIM_R_EN] & stop_right;

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_r        <= `MCIO_CTRL_RST;
			stored_addr_r <= `MCIO_STORED_RST;
			baud_r        <= `MCIO_BAUD_DEFAULT;
			adc_r         <= 12'h000;
			restore_r     <= 1'b0;
		end else begin
			if (adc_valid)
				adc_r <= adc_code;
			if (load_pulse && pad_short) begin
				// Settings back to factory values; store commits them for next boot
				ctrl_r        <= `MCIO_CTRL_RST;
				stored_addr_r <= `MCIO_STORED_RST;
				baud_r        <= `MCIO_BAUD_DEFAULT;
				restore_r     <= 1'b1;
			end else if (wr_en && !short_q[0]) begin
				// Writes refused while a restore is in force this power cycle
				case (paddr)
					`MCIO_OFF_CTRL:   ctrl_r <= pwdata[`MCIO_CTRL_W-1:0];
					`MCIO_OFF_STORED: stored_addr_r <= pwdata[7:0];
					`MCIO_OFF_BAUD: begin
						if (pwdata != 32'h0 && pwdata <= `MCIO_BAUD_MAX)
							baud_r <= pwdata;
					end
					default: ;
				endcase
			end
		end
	end

	// ------------------------------------------------------------------
	// APB slave, zero wait states
	// ------------------------------------------------------------------
	reg  [31:0] rd_mux;
	reg         addr_ok;

	always @* begin
		rd_mux  = 32'h0;
		addr_ok = 1'b1;
		case (paddr)
			`MCIO_OFF_CTRL:   rd_mux = {27'h0, ctrl_r};
			`MCIO_OFF_STATUS: rd_mux = {24'h0, init_done, ain_level & ctrl_r[`MCIO_CTRL_AIN_DIG],
				blk_right, blk_left, usb_present, can_enable, short_q[0], pins_used};
			`MCIO_OFF_NODE:   rd_mux = {8'h0, canopen_node_id, reply_addr, module_addr};
			`MCIO_OFF_STORED: rd_mux = {24'h0, stored_addr_r};
			`MCIO_OFF_BAUD:   rd_mux = baud_r;
			`MCIO_OFF_ADC:    rd_mux = {20'h0, adc_r};
			`MCIO_OFF_MOTION: rd_mux = {30'h0, motor_dir, motor_step};
			default:          addr_ok = 1'b0;
		endcase
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata  <= 32'h0;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready  <= psel & ~penable;
			pslverr <= psel & ~penable & ~addr_ok;
			prdata  <= (psel & ~penable & ~pwrite & addr_ok) ? rd_mux : 32'h0;
		end
	end

	// ------------------------------------------------------------------
	// Address selection and interface outputs
	// ------------------------------------------------------------------
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			init_done       <= 1'b0;
			factory_restore <= 1'b0;
			module_addr     <= 8'h00;
			reply_addr      <= 8'h00;
			canopen_node_id <= 8'h00;
			rs485_baud      <= `MCIO_BAUD_DEFAULT;
			can_enable      <= 1'b0;
			motor_step      <= 1'b0;
			motor_dir       <= 1'b0;
		end else begin
			init_done       <= (state_r == S_RUN);
			factory_restore <= restore_r;
			rs485_baud      <= baud_r;
			can_enable      <= (state_r == S_RUN) & ~usb_present;
			if (pins_used) begin
				module_addr     <= {4'h0, pins_q};
				reply_addr      <= `MCIO_REPLY_PIN_ADDR;
				canopen_node_id <= ctrl_r[`MCIO_CTRL_CANOPEN] ? {4'h0, pins_q} : 8'h00;
			end else begin
				module_addr     <= stored_addr_r;
				reply_addr      <= stored_addr_r;
				canopen_node_id <= ctrl_r[`MCIO_CTRL_CANOPEN] ? stored_addr_r : 8'h00;
			end
			// Source select then limit gating; a blocked step is dropped, not delayed
			if (ctrl_r[`MCIO_CTRL_DRV_MODE]) begin
				motor_dir  <= ext_dir;
				motor_step <= ext_step & ~(ext_dir ? blk_right : blk_left);
			end else begin
				motor_dir  <= int_dir;
				motor_step <= int_step & ~(int_dir ? blk_right : blk_left);
			end
		end
	end

endmodule

// ==== inc/mcio_defs.vh ====
/*
 * Constants for the module configuration and I/O select block: register
 * offsets, field positions, reset values and timing figures.
 * Assumes inclusion by bare name from the design files.
 */
`ifndef MCIO_DEFS_VH
`define MCIO_DEFS_VH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define MCIO_OFF_CTRL        12'h000
`define MCIO_OFF_STATUS      12'h004
`define MCIO_OFF_NODE        12'h008
`define MCIO_OFF_STORED      12'h00c
`define MCIO_OFF_BAUD        12'h010
`define MCIO_OFF_ADC         12'h014
`define MCIO_OFF_MOTION      12'h018

// ----------------------------------------------------------------------
// Control fields
// ----------------------------------------------------------------------
`define MCIO_CTRL_LIM_L_EN   0
`define MCIO_CTRL_LIM_R_EN   1
`define MCIO_CTRL_CANOPEN    2
`define MCIO_CTRL_DRV_MODE   3
`define MCIO_CTRL_AIN_DIG    4
`define MCIO_CTRL_W          5
`define MCIO_CTRL_RST        5'h00

// ----------------------------------------------------------------------
// Status fields
// ----------------------------------------------------------------------
`define MCIO_ST_PINS_USED    0
`define MCIO_ST_FACT_RST     1
`define MCIO_ST_CAN_EN       2
`define MCIO_ST_USB          3
`define MCIO_ST_LIM_L_BLK    4
`define MCIO_ST_LIM_R_BLK    5
`define MCIO_ST_AIN_DIG      6
`define MCIO_ST_INIT_DONE    7

// ----------------------------------------------------------------------
// Addresses, rates, converter
// ----------------------------------------------------------------------
`define MCIO_REPLY_PIN_ADDR  8'hff
`define MCIO_NODE_PINS_ZERO  4'h0
`define MCIO_STORED_RST      8'h01
`define MCIO_BAUD_DEFAULT    32'h00002580
`define MCIO_BAUD_MAX        32'h000f4240
`define MCIO_ADC_W           12
`define MCIO_ADC_MID         12'h800
`define MCIO_CLK_HZ          125000000
`define MCIO_INIT_US         2
`define MCIO_INIT_CYC        ((`MCIO_CLK_HZ / 1000000) * `MCIO_INIT_US)

`endif

// ==== verilog/mcio_pin_latch.v ====
/*
 * Power-up capture register: takes a value once on a load pulse and
 * holds it until the next reset.
 * Assumes the load pulse comes from the init sequencer of the top.
 */
`timescale 1ns/1ns
module mcio_pin_latch #(
	parameter W = 4
) (
	input  wire         pclk,     // Clock
	input  wire         presetn,  // Async reset, active low
	input  wire         load,     // One-cycle capture pulse
	input  wire [W-1:0] d,        // Value to capture
	output reg  [W-1:0] q         // Held value
);
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q <= {W{1'b0}};
		end else if (load) begin
			q <= d;
		end
	end
endmodule

// ==== dv/mcio_host.sv ====
/*
 * Host-side APB master model for the configuration block.
 * Assumes a single clock and a slave that answers with pready.
 */
`timescale 1ns/1ns
module mcio_host (
	input  wire logic        pclk,             // Clock
	output logic             psel    = 1'b0,   // Select
	output logic             penable = 1'b0,   // Enable
	output logic             pwrite  = 1'b0,   // Direction
	output logic [11:0]      paddr   = 12'h000, // Byte address
	output logic [31:0]      pwdata  = 32'h0,  // Write data
	input  wire logic [31:0] prdata,           // Read data
	input  wire logic        pready,           // Ready
	input  wire logic        pslverr           // Error
);
	// Request held until pready is seen high; only the bench watchdog ends a wait
	task xfer(input logic wr, input logic [11:0] a, input logic [31:0] wd,
		output logic [31:0] rd, output logic err);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
endmodule

// ==== dv/mcio_asserts.sv ====
/*
 * Port-level checker for the configuration block.
 * Assumes pins stay still across power-up sampling.
 */
`timescale 1ns/1ns
module mcio_asserts (
	input logic        pclk, presetn, psel, penable, pwrite, pready, factory_restore, init_done,
	input logic        node_sel_bit0, node_sel_bit1, node_sel_bit2, node_sel_bit3, usb_present,
	input logic        can_enable, stop_left, stop_right, ext_step, ext_dir, int_step, int_dir,
	input logic        motor_step, motor_dir,
	input logic [11:0] paddr,
	input logic [31:0] pwdata, rs485_baud,
	input logic [7:0]  module_addr, reply_addr, canopen_node_id
);
	logic [4:0] ctrl_m;
	logic [3:0] pins_m;
	wire        src_dir  = ctrl_m[3] ? ext_dir : int_dir;
	wire        src_step = ctrl_m[3] ? ext_step : int_step;
	wire        neg_blk  = ctrl_m[0] && stop_left && !src_dir;
	wire        pos_blk  = ctrl_m[1] && stop_right && src_dir;
	wire        pins_on  = init_done && pins_m != 4'h0;
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Mirror of the control word; writes are dropped during a restore cycle
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_m <= 5'h00;
			pins_m <= 4'h0;
		end else begin
			if (psel && penable && pready && pwrite && paddr == 12'h000 && !factory_restore)
				ctrl_m <= pwdata[4:0];
			if (!init_done)
				pins_m <= {node_sel_bit3, node_sel_bit2, node_sel_bit1, node_sel_bit0};
		end
	end
	sequence pins_held; pins_on ##1 pins_on; endsequence
	left_stop_a: assert property (neg_blk |=> !motor_step) else $error("step passed left stop");
	right_stop_a: assert property (pos_blk |=> !motor_step) else $error("step passed right stop");
	step_follow_a: assert property (!neg_blk && !pos_blk |=> motor_step == $past(src_step))
		else $error("step not following source");
	dir_follow_a: assert property (1'b1 |=> motor_dir == $past(src_dir)) else $error("dir mismatch");
	mod_pin_a: assert property (pins_on |-> module_addr == {4'h0, pins_m}) else $error("pin addr");
	reply_pin_a: assert property (pins_on |-> reply_addr == 8'hff) else $error("reply addr");
	node_pin_a: assert property (pins_on && ctrl_m[2] |=> canopen_node_id == {4'h0, pins_m})
		else $error("node id");
	pins_kept_a: assert property (pins_held |-> $stable(module_addr)) else $error("addr moved");
	can_gate_a: assert property (1'b1 |=> can_enable == (init_done && !$past(usb_present)))
		else $error("can gate");
	baud_range_a: assert property (rs485_baud != 32'h0 && rs485_baud <= 32'd1000000)
		else $error("baud range");
	restore_dflt_a: assert property (factory_restore |-> rs485_baud == 32'd9600)
		else $error("restore baud");
endmodule
bind mcio_top mcio_asserts u_mcio_asserts (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .pready(pready), .factory_restore(factory_restore), .init_done(init_done),
	.node_sel_bit0(node_sel_bit0), .node_sel_bit1(node_sel_bit1), .node_sel_bit2(node_sel_bit2),
	.node_sel_bit3(node_sel_bit3), .usb_present(usb_present), .can_enable(can_enable),
	.stop_left(stop_left), .stop_right(stop_right), .ext_step(ext_step), .ext_dir(ext_dir),
	.int_step(int_step), .int_dir(int_dir), .motor_step(motor_step), .motor_dir(motor_dir),
	.paddr(paddr), .pwdata(pwdata), .rs485_baud(rs485_baud), .module_addr(module_addr),
	.reply_addr(reply_addr), .canopen_node_id(canopen_node_id));

// ==== dv/test_mcio_top.sv ====
/*
 * Self-checking bench for the configuration block.
 * Assumes the host model and the bound checker are compiled alongside.
 */
`timescale 1ns/1ns
`include "mcio_defs.vh"
module test_mcio_top;
	logic pclk = 1'b0, presetn = 1'b0, usb_present = 1'b0, stop_left = 1'b0, stop_right = 1'b0;
	logic node_sel_bit0 = 1'b0, node_sel_bit1 = 1'b0, node_sel_bit2 = 1'b0, node_sel_bit3 = 1'b0;
	logic prog_clk_pad = 1'b0, prog_data_pad = 1'b0, ext_step = 1'b0, ext_dir = 1'b0;
	logic int_step = 1'b0, int_dir = 1'b0, adc_valid = 1'b0, ain_level = 1'b0;
	logic [11:0] adc_code = 12'h000;
	wire psel, penable, pwrite, pready, pslverr, init_done, factory_restore, can_enable, motor_step, motor_dir;
	wire [11:0] paddr;
	wire [31:0] pwdata, prdata, rs485_baud;
	wire [7:0]  module_addr, reply_addr, canopen_node_id;
	logic [31:0] r;
	logic        e;
	int          error_cnt = 0, tests_run = 0;
	always #4 pclk = ~pclk;
	mcio_top #(.INIT_CYC(4)) u_mcio_top (.*);
	mcio_host u_mcio_host (.*);
	task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		tests_run++;
		if (got !== exp) begin
			error_cnt++;
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task wr(input logic [11:0] a, input logic [31:0] d);
		u_mcio_host.xfer(1'b1, a, d, r, e);
		repeat (3) @(posedge pclk);
	endtask
	task boot(input logic [3:0] p, input logic sh);
		int n;
		n = 0;
		@(posedge pclk);
		presetn <= 1'b0;
		{node_sel_bit3, node_sel_bit2, node_sel_bit1, node_sel_bit0} <= p;
		{prog_clk_pad, prog_data_pad} <= {sh, sh};
		// Step sources quiet across reset so the follow checks start from a known source
		{stop_left, stop_right, ext_dir, ext_step, int_dir, int_step} <= 6'h00;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		while (init_done !== 1'b1 && n < 100) begin
			@(posedge pclk);
			n++;
		end
		chk("init_done", 32'h1, {31'h0, init_done});
		repeat (2) @(posedge pclk);
	endtask
	// Internal source is driven inverted so the driver-mode select shows
	task mv(input logic [3:0] v, input logic [1:0] ex);
		{stop_left, stop_right, ext_dir, ext_step} <= v;
		{int_dir, int_step} <= ~v[1:0];
		repeat (2) @(posedge pclk);
		chk("motor", {30'h0, ex}, {30'h0, motor_dir, motor_step});
	endtask
	task t_pins;
		boot(4'ha, 1'b0);
		chk("module_addr", 32'h0a, {24'h0, module_addr});
		chk("reply_addr", 32'hff, {24'h0, reply_addr});
		chk("baud", 32'd9600, rs485_baud);
		{node_sel_bit3, node_sel_bit2, node_sel_bit1, node_sel_bit0} <= 4'h5;
		repeat (3) @(posedge pclk);
		chk("held_addr", 32'h0a, {24'h0, module_addr});
	endtask
	task t_baud;
		wr(`MCIO_OFF_BAUD, 32'd1000000);
		chk("baud_max", 32'd1000000, rs485_baud);
		wr(`MCIO_OFF_BAUD, 32'd1000001);
		chk("baud_over", 32'd1000000, rs485_baud);
		wr(`MCIO_OFF_BAUD, 32'h0);
		chk("baud_zero", 32'd1000000, rs485_baud);
		u_mcio_host.xfer(1'b0, 12'h01c, 32'h0, r, e);
		chk("unmapped_err", 32'h1, {31'h0, e});
	endtask
	task t_limits;
		wr(`MCIO_OFF_CTRL, 32'h3);
		mv(4'b1010, 2'b00);
		mv(4'b1000, 2'b11);
		mv(4'b0110, 2'b01);
		mv(4'b0100, 2'b10);
		wr(`MCIO_OFF_CTRL, 32'h8);
		mv(4'b1111, 2'b11);
	endtask
	task t_io;
		usb_present <= 1'b1;
		repeat (2) @(posedge pclk);
		chk("can_usb", 32'h0, {31'h0, can_enable});
		usb_present <= 1'b0;
		adc_code <= 12'hfff;
		adc_valid <= 1'b1;
		@(posedge pclk);
		adc_valid <= 1'b0;
		ain_level <= 1'b1;
		@(posedge pclk);
		chk("can_free", 32'h1, {31'h0, can_enable});
		u_mcio_host.xfer(1'b0, `MCIO_OFF_ADC, 32'h0, r, e);
		chk("adc_full", 32'hfff, r);
		wr(`MCIO_OFF_CTRL, 32'h14);
		u_mcio_host.xfer(1'b0, `MCIO_OFF_STATUS, 32'h0, r, e);
		chk("ain_digital", 32'h1, {31'h0, r[6]});
		chk("node_id", 32'h0a, {24'h0, canopen_node_id});
	endtask
	task t_restore;
		boot(4'h0, 1'b1);
		chk("restore", 32'h1, {31'h0, factory_restore});
		wr(`MCIO_OFF_BAUD, 32'd19200);
		chk("restore_baud", 32'd9600, rs485_baud);
		chk("stored_addr", 32'h1, {24'h0, module_addr});
		boot(4'h0, 1'b0);
		wr(`MCIO_OFF_STORED, 32'h5);
		chk("stored_new", 32'h5, {24'h0, module_addr});
		chk("stored_reply", 32'h5, {24'h0, reply_addr});
		wr(`MCIO_OFF_CTRL, 32'h4);
		chk("stored_node", 32'h5, {24'h0, canopen_node_id});
	endtask
	task close_out;
		$display("comparisons %0d mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	initial begin
		t_pins;
		t_baud;
		t_limits;
		t_io;
		t_restore;
		close_out;
	end
	// Whole run is well under 1000 cycles
	initial begin
		#40000;
		error_cnt++;
		close_out;
	end
endmodule
